// ---- dv/client_lookup_model.sv ----
// Purpose: client bus master that tags transactions with a stream identifier
// Assumes: one lookup at a time, answer registered one cycle after the request
// Notes: the idle id is the inverse of the last one so a stale id never matches by luck
`timescale 1ns/10ps
`default_nettype none
module client_lookup_model
  import stream_match_pkg::*;
#(
  parameter int unsigned ID_W = 4,
  parameter int unsigned NUM_ENTRIES = 4
) (
  // clock
  input wire logic aclk,
  // request
  output logic lookup_valid,
  output logic [ID_W-1:0] stream_identifier,
  // answer
  input wire logic lookup_done,
  input wire logic lookup_hit,
  input wire logic lookup_multi_hit,
  input wire logic [$clog2(NUM_ENTRIES)-1:0] group_index
);
  initial begin
    lookup_valid = 1'b0;
    stream_identifier = '0;
  end
  // called only while the table is settled, never during reprogramming
  task automatic issue(input logic [ID_W-1:0] id, output logic h, output logic m,
                       output logic [$clog2(NUM_ENTRIES)-1:0] x, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge aclk);
    lookup_valid <= 1'b1;
    stream_identifier <= id;
    @(posedge aclk);
    lookup_valid <= 1'b0;
    stream_identifier <= ~id;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge aclk);
      if (lookup_done === 1'b1) begin
        ok = 1'b1;
        h = lookup_hit;
        m = lookup_multi_hit;
        x = group_index;
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/stream_match_tlb_invalidate_test.sv ----
// Purpose: self-checking bench for the stream match table and invalidate commands
// Assumes: 4 entries with 4 implemented id and mask bits
// Notes: invalidates go over the register bus; tlb state is watched inside the top
`timescale 1ns/10ps
`default_nettype none
module stream_match_tlb_invalidate_test
  import stream_match_pkg::*;
;
  localparam int unsigned NE = 4;
  localparam int unsigned IW = 4;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb, fill_index;
  logic [1:0] bresp, rresp, gidx, fill_tag;
  logic lk_valid, lk_done, lk_hit, lk_multi, fill_valid, fill_lock;
  logic [IW-1:0] lk_id;
  int err_count, compares;

  stream_match_tlb_invalidate #(.NUM_ENTRIES(NE), .ID_W(IW), .MASK_W(IW)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .lookup_valid(lk_valid), .stream_identifier(lk_id), .lookup_done(lk_done),
    .lookup_hit(lk_hit), .lookup_multi_hit(lk_multi), .group_index(gidx),
    .fill_valid(fill_valid), .fill_index(fill_index), .fill_tag(fill_tag), .fill_lock(fill_lock));
  client_lookup_model #(.ID_W(IW), .NUM_ENTRIES(NE)) client (
    .aclk(aclk), .lookup_valid(lk_valid), .stream_identifier(lk_id), .lookup_done(lk_done),
    .lookup_hit(lk_hit), .lookup_multi_hit(lk_multi), .group_index(gidx));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic summarize();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic timed_out(input string what);
    err_count++;
    $display("BAD %s expected answer seen none", what);
    summarize();
  endtask
  task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_flag(input string what, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask

  // write address and data offered together, each released once taken
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] e);
    int n;
    logic [1:0] r;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        n = 99;
      end
    end
    if (n != 99) timed_out("write response");
    check_val("bresp", 32'(e), 32'(r));
  endtask
  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        check_val("rdata", e, rdata);
        check_val("rresp", 32'(er), 32'(rresp));
        rready <= 1'b0;
        n = 99;
      end
    end
    if (n != 99) timed_out("read data");
  endtask
  task automatic lookup(input logic [IW-1:0] id, input logic eh, input logic em, input logic [1:0] ei);
    logic h, m;
    logic [1:0] x;
    bit ok;
    client.issue(id, h, m, x, ok);
    if (!ok) timed_out("lookup done");
    check_flag("lookup hit", eh, h);
    check_flag("lookup multi hit", em, m);
    check_val("group index", 32'(ei), 32'(x));
  endtask

  task automatic entry_scenario();
    reg_wr(ENTRY_BASE + 12'hC, 32'hFFFF_FFFF, RESP_OKAY);
    reg_rd(ENTRY_BASE + 12'hC, 32'h800F_000F, RESP_OKAY);
    reg_wr(ENTRY_BASE + 12'h4, 32'h0003_0002, RESP_OKAY);
    reg_rd(ENTRY_BASE + 12'h4, 32'h0003_0002, RESP_OKAY);
  endtask
  task automatic match_scenario();
    // all entries out of the search before any is reprogrammed
    for (int i = 0; i < NE; i++) reg_wr(ENTRY_BASE + 12'(4 * i), 32'h8000_0000, RESP_OKAY);
    lookup(4'h0, 1'b0, 1'b0, 2'h0);
    reg_wr(ENTRY_BASE, 32'h8000_0005, RESP_OKAY);
    reg_wr(ENTRY_BASE + 12'h4, 32'h0000_0005, RESP_OKAY);
    reg_wr(ENTRY_BASE + 12'h8, 32'h0001_0004, RESP_OKAY);
    lookup(4'h4, 1'b1, 1'b0, 2'h2);
    lookup(4'h5, 1'b1, 1'b1, 2'h1);
    lookup(4'h7, 1'b0, 1'b0, 2'h0);
    reg_wr(ENTRY_BASE, 32'h0000_0005, RESP_OKAY);
    lookup(4'h5, 1'b1, 1'b1, 2'h0);
  endtask
  task automatic cmd_scenario();
    reg_wr(SECURE_INV_OFF, 32'hFFFF_FFFF, RESP_OKAY);
    reg_wr(HYP_INV_OFF, 32'h0000_0000, RESP_OKAY);
    reg_wr(NSG_INV_OFF, 32'h1234_5678, RESP_OKAY);
    reg_rd(HYP_INV_OFF, 32'h0000_0000, RESP_OKAY);
    reg_rd(STATUS_OFF, 32'h0000_0003, RESP_OKAY);
    reg_rd(CONFIG_OFF, 32'h0304_0404, RESP_OKAY);
    reg_rd(12'h900, 32'h0000_0000, RESP_SLVERR);
    reg_wr(12'h900, 32'h0000_0001, RESP_SLVERR);
  endtask
  task automatic tlb_scenario();
    // entries 0..2 unlocked secure, hyp, guest; 3..5 the same tags locked
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      fill_valid <= 1'b1;
      fill_index <= 4'(i);
      fill_tag <= 2'(i % 3);
      fill_lock <= (i > 2);
    end
    @(posedge aclk);
    fill_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    check_val("tlb valid after fill", 32'h0000_003F, 32'(uut.tlb_valid));
    // secure, hyp, guest commands in turn; the tlb drops entries on the edge bvalid is seen
    for (int i = 0; i < 3; i++) begin
      reg_wr(SECURE_INV_OFF + 12'(4 * i), 32'h0000_0000, RESP_OKAY);
      @(posedge aclk);
      check_val("tlb valid after invalidate", 32'h3F & ~((32'h2 << i) - 1), 32'(uut.tlb_valid));
    end
    check_val("tlb locked", 32'h0000_0038, 32'(uut.tlb_locked));
  endtask

  initial begin
    err_count = 0;
    compares = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, fill_valid, fill_lock} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    fill_index = '0;
    fill_tag = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    entry_scenario();
    match_scenario();
    cmd_scenario();
    tlb_scenario();
    summarize();
  end
endmodule
`default_nettype wire

// ---- pkg/stream_match_pkg.sv ----
// Purpose: shared constants for the stream match table and tlb invalidate block
// Assumes: 32-bit axi4-lite register bus, word-aligned registers
// Notes: offsets are byte addresses
package stream_match_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  // entry field layout
  localparam int unsigned SEARCH_OFF_BIT = 31;
  localparam int unsigned MASK_LSB = 16;
  localparam int unsigned MASK_FULL_W = 15;
  localparam int unsigned ID_LSB = 0;
  localparam int unsigned ID_FULL_W = 15;
  // register map
  localparam logic [ADDR_W-1:0] ENTRY_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] SECURE_INV_OFF = 12'h800;
  localparam logic [ADDR_W-1:0] HYP_INV_OFF = 12'h804;
  localparam logic [ADDR_W-1:0] NSG_INV_OFF = 12'h808;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h80C;
  localparam logic [ADDR_W-1:0] CONFIG_OFF = 12'h810;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // tlb entry tags
  localparam logic [1:0] TAG_SECURE = 2'h0;
  localparam logic [1:0] TAG_HYP = 2'h1;
  localparam logic [1:0] TAG_NSG = 2'h2;
  // invalidate command codes
  localparam logic [1:0] INV_NONE = 2'h0;
  localparam logic [1:0] INV_SECURE = 2'h1;
  localparam logic [1:0] INV_HYP = 2'h2;
  localparam logic [1:0] INV_NSG = 2'h3;
endpackage

// ---- verilog/stream_match_tlb_invalidate.sv ----
// Purpose: stream match table, tlb invalidate-all commands, axi4-lite slave
// Assumes: single clock, synchronous active-low reset, 32-bit axi4-lite
// Notes: match entries have no reset value; software must program them first
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module stream_match_tlb_invalidate
  import stream_match_pkg::*;
#(
  parameter int unsigned NUM_ENTRIES = 8,
  parameter int unsigned ID_W = 15,
  parameter int unsigned MASK_W = 15,
  parameter int unsigned TLB_ENTRIES = 16,
  parameter bit HAS_SECURITY = 1'b1,
  parameter bit ID_MATCHING = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transaction lookup
  input wire logic lookup_valid,
  input wire logic [ID_W-1:0] stream_identifier,
  output logic lookup_done,
  output logic lookup_hit,
  output logic lookup_multi_hit,
  output logic [$clog2(NUM_ENTRIES)-1:0] group_index,
  // tlb fill
  input wire logic fill_valid,
  input wire logic [$clog2(TLB_ENTRIES)-1:0] fill_index,
  input wire logic [1:0] fill_tag,
  input wire logic fill_lock
);
  localparam int unsigned IDX_W = $clog2(NUM_ENTRIES);

  // one width for every entry by construction
  initial begin
    if (ID_W < 1 || ID_W > ID_FULL_W || MASK_W > MASK_FULL_W || MASK_W > ID_W) begin
      $error("unsupported identifier or mask width");
    end
    if (NUM_ENTRIES < 2 || NUM_ENTRIES > 256 || TLB_ENTRIES < 2) begin
      $error("unsupported table size");
    end
  end

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic [1:0] inv_cmd;
    logic [15:0] inv_count;
    logic lk_done;
    logic lk_hit;
    logic lk_multi;
    logic [IDX_W-1:0] lk_index;
  } ctl_s;
  ctl_s s_q, s_d;

  // entries are kept outside the struct: they have no reset value
  logic [NUM_ENTRIES-1:0] search_off_q;
  logic [NUM_ENTRIES*ID_W-1:0] id_q;
  logic [NUM_ENTRIES*ID_W-1:0] mask_q;

  logic wr_fire, ent_wr, m_hit, m_multi;
  logic [IDX_W-1:0] m_index;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_word;
  logic [TLB_ENTRIES-1:0] tlb_valid, tlb_locked;

  function automatic logic is_entry(input logic [ADDR_W-1:0] a);
    is_entry = (a >= ENTRY_BASE) && (a < ENTRY_BASE + ADDR_W'(NUM_ENTRIES * 4));
  endfunction

  function automatic logic [IDX_W-1:0] entry_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ENTRY_BASE;
    entry_idx = off[IDX_W+1:2];
  endfunction

  // read value of one entry; unimplemented bits and bit 15 read zero
  function automatic logic [DATA_W-1:0] entry_word(input int unsigned k,
      input logic [NUM_ENTRIES-1:0] off, input logic [NUM_ENTRIES*ID_W-1:0] ids,
      input logic [NUM_ENTRIES*ID_W-1:0] masks);
    logic [DATA_W-1:0] w;
    w = '0;
    w[SEARCH_OFF_BIT] = off[k];
    for (int b = 0; b < MASK_W; b++) begin
      w[MASK_LSB+b] = masks[k*ID_W+b];
    end
    for (int b = 0; b < ID_W; b++) begin
      w[ID_LSB+b] = ids[k*ID_W+b];
    end
    entry_word = w;
  endfunction

  // merge byte strobes into the current word
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] nw, input logic [3:0] strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign ent_wr = wr_fire && ID_MATCHING && is_entry(s_q.aw_addr);
  assign wr_idx = entry_idx(s_q.aw_addr);
  assign wr_word = merge(entry_word(wr_idx, search_off_q, id_q, mask_q), s_q.w_data, s_q.w_strb);

  always_comb begin
    s_d = s_q;
    s_d.inv_cmd = INV_NONE;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      // command data bits are reserved and ignored
      if (s_q.aw_addr == SECURE_INV_OFF && HAS_SECURITY) begin
        s_d.inv_cmd = INV_SECURE;
      end else if (s_q.aw_addr == HYP_INV_OFF) begin
        s_d.inv_cmd = INV_HYP;
      end else if (s_q.aw_addr == NSG_INV_OFF) begin
        s_d.inv_cmd = INV_NSG;
      end else if (!is_entry(s_q.aw_addr) && s_q.aw_addr != SECURE_INV_OFF) begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_d.inv_cmd != INV_NONE) begin
      s_d.inv_count = s_q.inv_count + 16'h0001;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      if (is_entry(s_axi_araddr)) begin
        if (ID_MATCHING) begin
          s_d.rdata = entry_word(entry_idx(s_axi_araddr), search_off_q, id_q, mask_q);
        end
      end else if (s_axi_araddr == STATUS_OFF) begin
        s_d.rdata = {16'h0000, s_q.inv_count};
      end else if (s_axi_araddr == CONFIG_OFF) begin
        s_d.rdata = {6'h00, ID_MATCHING, HAS_SECURITY, 8'(NUM_ENTRIES), 8'(MASK_W), 8'(ID_W)};
      end else if (s_axi_araddr == SECURE_INV_OFF || s_axi_araddr == HYP_INV_OFF ||
          s_axi_araddr == NSG_INV_OFF) begin
        s_d.rdata = '0;
      end else begin
        s_d.rresp = RESP_SLVERR;
      end
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // registered lookup result selects the mapping group
    s_d.lk_done = lookup_valid;
    s_d.lk_hit = lookup_valid && m_hit && ID_MATCHING;
    s_d.lk_multi = lookup_valid && m_multi && ID_MATCHING;
    s_d.lk_index = lookup_valid ? m_index : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // no reset on the table: contents are unknown until programmed
  always_ff @(posedge aclk) begin
    if (ent_wr) begin
      search_off_q[wr_idx] <= wr_word[SEARCH_OFF_BIT];
      id_q[wr_idx*ID_W +: ID_W] <= wr_word[ID_LSB +: ID_W];
      for (int b = 0; b < ID_W; b++) begin
        mask_q[wr_idx*ID_W+b] <= (b < MASK_W) ? wr_word[MASK_LSB+b] : 1'b0;
      end
    end
  end

  assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
  assign lookup_done = s_q.lk_done;
  assign lookup_hit = s_q.lk_hit;
  assign lookup_multi_hit = s_q.lk_multi;
  assign group_index = s_q.lk_index;

  stream_matcher #(
    .NUM_ENTRIES(NUM_ENTRIES),
    .ID_W(ID_W)
  ) u_matcher (
    .search_off(search_off_q),
    .entry_id(id_q),
    .entry_mask(mask_q),
    .stream_identifier(stream_identifier),
    .hit(m_hit),
    .multi_hit(m_multi),
    .hit_index(m_index)
  );

  tlb_tag_store #(
    .TLB_ENTRIES(TLB_ENTRIES)
  ) u_tlb (
    .aclk(aclk),
    .aresetn(aresetn),
    .fill_valid(fill_valid),
    .fill_index(fill_index),
    .fill_tag(fill_tag),
    .fill_lock(fill_lock),
    .inv_cmd(s_q.inv_cmd),
    .entry_valid(tlb_valid),
    .entry_locked(tlb_locked)
  );

  property p_wr_resp;
    @(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write not answered");

  property p_hyp_cmd;
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && s_q.aw_addr == HYP_INV_OFF) |=> (s_q.inv_cmd == INV_HYP);
  endproperty
  a_hyp_cmd: assert property (p_hyp_cmd) else $error("hyp invalidate not issued");

  property p_nsg_cmd;
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && s_q.aw_addr == NSG_INV_OFF) |=> (s_q.inv_cmd == INV_NSG);
  endproperty
  a_nsg_cmd: assert property (p_nsg_cmd) else $error("guest invalidate not issued");

  property p_sec_cmd;
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && s_q.aw_addr == SECURE_INV_OFF) |=> (s_q.inv_cmd == (HAS_SECURITY ? INV_SECURE : INV_NONE));
  endproperty
  a_sec_cmd: assert property (p_sec_cmd) else $error("secure invalidate mishandled");

  property p_excluded_no_hit;
    @(posedge aclk) disable iff (!aresetn)
    (lookup_valid && search_off_q == '1) |=> !lookup_hit;
  endproperty
  a_excluded_no_hit: assert property (p_excluded_no_hit) else $error("excluded entry matched");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && is_entry(s_axi_araddr)) |=> (s_axi_rdata[15] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit reads one");

  property p_index_mode_zero;
    @(posedge aclk) disable iff (!aresetn)
    (!ID_MATCHING && s_axi_arvalid && s_axi_arready && is_entry(s_axi_araddr)) |=> (s_axi_rdata == '0);
  endproperty
  a_index_mode_zero: assert property (p_index_mode_zero) else $error("indexing mode entry not zero");

  property p_hit_needs_lookup;
    @(posedge aclk) disable iff (!aresetn)
    lookup_hit |-> lookup_done;
  endproperty
  a_hit_needs_lookup: assert property (p_hit_needs_lookup) else $error("hit without lookup");

  property p_locked_kept;
    @(posedge aclk) disable iff (!aresetn)
    (s_q.inv_cmd != INV_NONE && !fill_valid) |=> ((tlb_valid & tlb_locked) == $past(tlb_valid & tlb_locked));
  endproperty
  a_locked_kept: assert property (p_locked_kept) else $error("locked tlb entry dropped by a command");
endmodule
`default_nettype wire

// ---- verilog/stream_matcher.sv ----
// Purpose: combinational search of the stream match table
// Assumes: entries are already masked to implemented bits
// Notes: lowest matching index wins; multiple hits are flagged
`timescale 1ns/10ps
`default_nettype none
module stream_matcher
  import stream_match_pkg::*;
#(
  parameter int unsigned NUM_ENTRIES = 8,
  parameter int unsigned ID_W = 15
) (
  // table
  input wire logic [NUM_ENTRIES-1:0] search_off,
  input wire logic [NUM_ENTRIES*ID_W-1:0] entry_id,
  input wire logic [NUM_ENTRIES*ID_W-1:0] entry_mask,
  // lookup
  input wire logic [ID_W-1:0] stream_identifier,
  output logic hit,
  output logic multi_hit,
  output logic [$clog2(NUM_ENTRIES)-1:0] hit_index
);
  logic [NUM_ENTRIES-1:0] hits;
  genvar g;
  generate
    for (g = 0; g < NUM_ENTRIES; g++) begin : g_cmp
      // xor under inverted mask; excluded entries never hit
      assign hits[g] = !search_off[g] &&
        (((stream_identifier ^ entry_id[g*ID_W +: ID_W]) & ~entry_mask[g*ID_W +: ID_W]) == '0);
    end
  endgenerate

  always_comb begin
    hit_index = '0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
      if (hits[i]) begin
        hit_index = i[$clog2(NUM_ENTRIES)-1:0];
      end
    end
  end

  assign hit = |hits;
  assign multi_hit = (hits & (hits - 1'b1)) != '0;
endmodule
`default_nettype wire

// ---- verilog/tlb_tag_store.sv ----
// Purpose: small tlb valid/lock/tag store with global invalidate commands
// Assumes: fills come from the translation side, one per cycle
// Notes: locked entries survive every invalidate-all
`timescale 1ns/10ps
`default_nettype none
module tlb_tag_store
  import stream_match_pkg::*;
#(
  parameter int unsigned TLB_ENTRIES = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // fill
  input wire logic fill_valid,
  input wire logic [$clog2(TLB_ENTRIES)-1:0] fill_index,
  input wire logic [1:0] fill_tag,
  input wire logic fill_lock,
  // command
  input wire logic [1:0] inv_cmd,
  // state
  output logic [TLB_ENTRIES-1:0] entry_valid,
  output logic [TLB_ENTRIES-1:0] entry_locked
);
  typedef struct packed {
    logic [TLB_ENTRIES-1:0] valid;
    logic [TLB_ENTRIES-1:0] lock;
    logic [TLB_ENTRIES-1:0][1:0] tag;
  } tlb_s;
  tlb_s s_q, s_d;

  function automatic logic tag_hit(input logic [1:0] cmd, input logic [1:0] tag);
    case (cmd)
      INV_SECURE: tag_hit = (tag == TAG_SECURE);
      INV_HYP: tag_hit = (tag == TAG_HYP);
      INV_NSG: tag_hit = (tag == TAG_NSG);
      default: tag_hit = 1'b0;
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < TLB_ENTRIES; i++) begin
      // only unlocked entries of the named tag are dropped
      if (s_q.valid[i] && !s_q.lock[i] && tag_hit(inv_cmd, s_q.tag[i])) begin
        s_d.valid[i] = 1'b0;
      end
    end
    // a fill in the invalidate cycle is kept
    if (fill_valid) begin
      s_d.valid[fill_index] = 1'b1;
      s_d.lock[fill_index] = fill_lock;
      s_d.tag[fill_index] = fill_tag;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign entry_valid = s_q.valid;
  assign entry_locked = s_q.lock;

  property p_lock_survives;
    @(posedge aclk) disable iff (!aresetn)
    (!fill_valid && (s_q.valid & s_q.lock) != '0) |=>
      ((s_q.valid & $past(s_q.valid & s_q.lock)) == $past(s_q.valid & s_q.lock));
  endproperty
  a_lock_survives: assert property (p_lock_survives) else $error("locked entry lost");

  property p_inv_drops;
    @(posedge aclk) disable iff (!aresetn)
    (inv_cmd != INV_NONE && s_q.valid[0] && !s_q.lock[0] && tag_hit(inv_cmd, s_q.tag[0])
      && !(fill_valid && fill_index == '0)) |=> !s_q.valid[0];
  endproperty
  a_inv_drops: assert property (p_inv_drops) else $error("unlocked entry not invalidated");
endmodule
`default_nettype wire
